// ===== core/adcc_defs.vh
// constants for the converter control block
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH
`define ADCC_CH_W 5
`define ADCC_CH_REFH 5'h1d
`define ADCC_CH_REFL 5'h1e
`define ADCC_CH_OFF 5'h1f
`define ADCC_FULL_SCALE 10'h3ff
`define ADCC_ZERO_SCALE 10'h000
`define ADCC_MODE_LEFT 2'h0
`define ADCC_MODE_RIGHT 2'h1
`define ADCC_MODE_SIGNED 2'h2
`define ADCC_MODE_TRUNC 2'h3
`define ADCC_CONV_CYCLES 5'h10
`define ADCC_SETTLE_CYCLES 5'h11
`define ADCC_DIV_W 3
`define ADCC_CNT_W 5
`endif

// ===== core/adcc_clk_div.v
// divider making the converter clock tick from a selected source
`timescale 1ns/100ps
module adcc_clk_div #(
  parameter DIV_W = 3
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // configuration
  input wire srcSel,
  input wire oscTick,
  input wire [DIV_W-1:0] divSel,
  input wire run,
  // tick out
  output reg convTick_ff
);
  reg [3:0] cnt_ff;
  reg [3:0] lastCount;
  wire srcTick;
  // bus clock when srcSel is set, oscillator tick otherwise
  assign srcTick = srcSel ? 1'b1 : oscTick;
  always @* begin
    if (divSel[2]) begin
      lastCount = 4'hf;
    end else begin
      lastCount = (4'h1 << divSel[1:0]) - 4'h1;
    end
  end
  always @(posedge clk) begin
    if (reset || !run) begin
      cnt_ff <= 4'h0;
      convTick_ff <= 1'b0;
    end else if (srcTick) begin
      convTick_ff <= (cnt_ff == lastCount);
      cnt_ff <= (cnt_ff == lastCount) ? 4'h0 : cnt_ff + 4'h1;
    end else begin
      convTick_ff <= 1'b0;
    end
  end
endmodule

// ===== core/adcc_pin_mux.v
// one shared port pin, taken over when selected by the converter
`timescale 1ns/100ps
module adcc_pin_mux (
  // clock and reset
  input wire clk,
  input wire reset,
  // selection
  input wire selected,
  // port logic side
  input wire portOut,
  input wire portDir,
  input wire padIn,
  // pad side
  output reg padOut_ff,
  output reg padOe_ff,
  output reg portRead_ff,
  output reg analogSel_ff
);
  always @(posedge clk) begin
    if (reset) begin
      padOut_ff <= 1'b0;
      padOe_ff <= 1'b0;
      portRead_ff <= 1'b0;
      analogSel_ff <= 1'b0;
    end else begin
      analogSel_ff <= selected; // R1
      padOe_ff <= selected ? 1'b0 : portDir; // R2
      padOut_ff <= selected ? 1'b0 : portOut; // R4
      portRead_ff <= selected ? 1'b0 : padIn; // R3
    end
  end
endmodule

// ===== core/adcc_conv_ctrl.v
// converter control: pin takeover, conversion sequencing, result formatting
// Operation
// R1 - selected channel pin is forced to be the converter input
// R2 - port output and direction writes do not affect the selected pin
// R3 - port read of the selected pin returns zero
// R4 - other shared pins stay under normal port control
// R5 - result 3ff at high reference, 000 at low, linear between
// R6 - every status/control write starts a conversion; a write selecting channel 31 returns the sequencer to idle instead
// R7 - conversion takes 16 to 17 converter clock cycles
// R8 - software sets divider and source for about 1 MHz
// R9 - continuous mode overwrites result each conversion until bit cleared
// R10 - without interrupts, done flag sets per conversion, clears on data read
// R11 - single mode does one conversion per control write then stops
// R12 - software discards result of a conversion interrupted by a write
// R13 - two mode bits pick one of four result formats
// R14 - left mode: top eight bits high, lower two in low
// R15 - read low after high; until then no new result stored
// R16 - right mode: two top bits high, eight low bits in low
// R17 - signed mode is left mode with result msb inverted
// R18 - truncation: eight msbs in low, two dropped, no interlock
// R19 - with interrupt enabled, request per conversion, done flag stays zero
// R20 - converter keeps running in wait, its interrupt wakes the cpu
// R21 - software powers converter down before wait if no wake needed
// R22 - stop aborts conversion; after stop one settle period precedes result
// R23 - five bit channel field: 0-7 pins, 29/30 references, 31 off
// R24 - pending request clears on data read or control write
// R25 - control write during conversion restarts with new settings
`timescale 1ns/100ps
`include "adcc_defs.vh"
module adcc_conv_ctrl #(
  parameter NUM_PINS = 8,
  parameter RES_W = 10
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // status and control register write
  input wire ctrlWrite,
  input wire [`ADCC_CH_W-1:0] channelSelectField,
  input wire continuousModeBit,
  input wire convIrqEnable,
  // clock configuration register
  input wire justifyModeBit0,
  input wire justifyModeBit1,
  input wire [`ADCC_DIV_W-1:0] convClockDivider,
  input wire convClockSourceSel,
  input wire oscTick,
  // data register reads
  input wire resultHighRead,
  input wire resultLowRead,
  // low power modes
  input wire stopMode,
  // analog core
  input wire [RES_W-1:0] coreResult,
  // shared port pins
  input wire [NUM_PINS-1:0] portOut,
  input wire [NUM_PINS-1:0] portDir,
  input wire [NUM_PINS-1:0] padIn,
  output wire [NUM_PINS-1:0] padOut,
  output wire [NUM_PINS-1:0] padOe,
  output wire [NUM_PINS-1:0] portRead,
  output wire [NUM_PINS-1:0] selectedAnalogInput,
  // reference and power to analog core
  output reg highReferenceSel_ff,
  output reg lowReferenceSel_ff,
  output reg convPowerOn_ff,
  output reg sampleStrobe_ff,
  // registers seen by software
  output reg [7:0] resultHighReg_ff,
  output reg [7:0] resultLowReg_ff,
  output reg conversionDoneFlag_ff,
  output reg convIrq_ff,
  output reg busy_ff
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`ADCC_CNT_W-1:0] cnt_ff;
  reg [`ADCC_CNT_W-1:0] nxt_cnt;
  reg [`ADCC_CH_W-1:0] chan_ff;
  reg cont_ff;
  reg irqEn_ff;
  reg settle_ff;
  reg locked_ff;
  reg [7:0] fmtHigh;
  reg [7:0] fmtLow;
  wire [1:0] mode;
  wire convTick;
  wire running;
  wire finish;
  wire storeOk;
  wire dataRead;

  assign mode = {justifyModeBit1, justifyModeBit0}; // R13
  assign running = (state_ff == ST_CONV) && !stopMode;
  assign dataRead = resultHighRead || resultLowRead;
  assign finish = running && convTick &&
    (cnt_ff == (settle_ff ? `ADCC_SETTLE_CYCLES : `ADCC_CONV_CYCLES) - 5'h1); // R7
  // interlock holds off stores until the low half is read, except in truncation mode
  assign storeOk = !locked_ff || (mode == `ADCC_MODE_TRUNC); // R15 R18

  // ----------------------------------------------------------------
  // converter clock
  // ----------------------------------------------------------------
  adcc_clk_div #(
    .DIV_W(`ADCC_DIV_W)
  ) u_div (
    .clk(clk),
    .reset(reset),
    .srcSel(convClockSourceSel),
    .oscTick(oscTick),
    .divSel(convClockDivider),
    .run(running),
    .convTick_ff(convTick)
  );

  // ----------------------------------------------------------------
  // pin takeover
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
      localparam [`ADCC_CH_W-1:0] PIN_CODE = gi;
      adcc_pin_mux u_pin (
        .clk(clk),
        .reset(reset),
        .selected(chan_ff == PIN_CODE), // R1 R23
        .portOut(portOut[gi]),
        .portDir(portDir[gi]),
        .padIn(padIn[gi]),
        .padOut_ff(padOut[gi]),
        .padOe_ff(padOe[gi]),
        .portRead_ff(portRead[gi]),
        .analogSel_ff(selectedAnalogInput[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // result formatting
  // ----------------------------------------------------------------
  // core code is already 000..3ff across the reference span
  always @* begin
    fmtHigh = 8'h00;
    fmtLow = 8'h00;
    if (mode == `ADCC_MODE_LEFT) begin
      fmtHigh = coreResult[9:2]; // R14 R5
      fmtLow = {coreResult[1:0], 6'h00};
    end else if (mode == `ADCC_MODE_RIGHT) begin
      fmtHigh = {6'h00, coreResult[9:8]}; // R16
      fmtLow = coreResult[7:0];
    end else if (mode == `ADCC_MODE_SIGNED) begin
      fmtHigh = {~coreResult[9], coreResult[8:2]}; // R17
      fmtLow = {coreResult[1:0], 6'h00};
    end else begin
      fmtHigh = 8'h00; // R18
      fmtLow = coreResult[9:2];
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_cnt = 5'h00;
      end
      ST_CONV: begin
        if (finish) begin
          nxt_state = ST_DONE;
          nxt_cnt = 5'h00;
        end else if (running && convTick) begin
          nxt_cnt = cnt_ff + 5'h01;
        end
      end
      ST_DONE: begin
        // continuous runs on, single stops after one
        nxt_state = cont_ff ? ST_CONV : ST_IDLE; // R9 R11
        nxt_cnt = 5'h00;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (stopMode) begin
      nxt_cnt = 5'h00; // R22
    end
    if (ctrlWrite) begin
      nxt_cnt = 5'h00;
      nxt_state = (channelSelectField == `ADCC_CH_OFF) ? ST_IDLE : ST_CONV; // R6 R25 R23
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 5'h00;
      chan_ff <= `ADCC_CH_OFF;
      cont_ff <= 1'b0;
      irqEn_ff <= 1'b0;
      settle_ff <= 1'b1;
      locked_ff <= 1'b0;
      resultHighReg_ff <= 8'h00;
      resultLowReg_ff <= 8'h00;
      conversionDoneFlag_ff <= 1'b0;
      convIrq_ff <= 1'b0;
      busy_ff <= 1'b0;
      highReferenceSel_ff <= 1'b0;
      lowReferenceSel_ff <= 1'b0;
      convPowerOn_ff <= 1'b0;
      sampleStrobe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      busy_ff <= (nxt_state != ST_IDLE);
      sampleStrobe_ff <= finish && storeOk;
      if (ctrlWrite) begin
        chan_ff <= channelSelectField; // R25
        cont_ff <= continuousModeBit;
        irqEn_ff <= convIrqEnable;
      end
      highReferenceSel_ff <= (chan_ff == `ADCC_CH_REFH);
      lowReferenceSel_ff <= (chan_ff == `ADCC_CH_REFL);
      convPowerOn_ff <= (chan_ff != `ADCC_CH_OFF) && !stopMode;
      // recovery from off or stop needs one extra settling period
      if (stopMode || chan_ff == `ADCC_CH_OFF) begin
        settle_ff <= 1'b1; // R22
      end else if (finish) begin
        settle_ff <= 1'b0;
      end
      // high read arms the lock outside truncation mode, low read releases; low wins if both
      if (resultLowRead) begin
        locked_ff <= 1'b0; // R15
      end else if (resultHighRead && mode != `ADCC_MODE_TRUNC) begin
        locked_ff <= 1'b1;
      end
      if (finish && storeOk) begin
        resultHighReg_ff <= fmtHigh; // R9
        resultLowReg_ff <= fmtLow;
      end
      // set beats clear on the same cycle
      if (finish && !irqEn_ff) begin
        conversionDoneFlag_ff <= 1'b1; // R10
      end else if (dataRead || irqEn_ff) begin
        conversionDoneFlag_ff <= 1'b0; // R19
      end
      // request stays live in wait; only stop halts the sequencer
      if (finish && irqEn_ff) begin
        convIrq_ff <= 1'b1; // R19 R20
      end else if (dataRead || ctrlWrite) begin
        convIrq_ff <= 1'b0; // R24
      end
    end
  end
endmodule

// ===== dv/adcc_conv_ctrl_checker.sv
// assertion checker for the converter control block
`timescale 1ns/100ps
module adcc_conv_ctrl_checker #(
  parameter NUM_PINS = 8
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // inputs watched
  input wire ctrlWrite,
  input wire [4:0] channelSelectField,
  input wire [2:0] convClockDivider,
  input wire convClockSourceSel,
  input wire justifyModeBit0,
  input wire justifyModeBit1,
  input wire stopMode,
  input wire [NUM_PINS-1:0] portDir,
  // outputs watched
  input wire [NUM_PINS-1:0] padOe,
  input wire [NUM_PINS-1:0] portRead,
  input wire [NUM_PINS-1:0] selectedAnalogInput,
  input wire highReferenceSel_ff,
  input wire convPowerOn_ff,
  input wire sampleStrobe_ff,
  input wire [7:0] resultHighReg_ff,
  input wire [7:0] resultLowReg_ff,
  input wire conversionDoneFlag_ff,
  input wire convIrq_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----
  // sequences
  // ----
  sequence s_fast_start;
    ctrlWrite && channelSelectField != 5'h1f && convClockSourceSel && convClockDivider == 3'h0;
  endsequence
  sequence s_quiet;
    !conversionDoneFlag_ff && !convIrq_ff;
  endsequence
  a_sel_read_zero: assert property ((portRead & selectedAnalogInput) == 0)
    else $error("selected pin reads nonzero");
  a_sel_not_driven: assert property ((padOe & selectedAnalogInput) == 0)
    else $error("selected pin still driven");
  a_unsel_port_ctrl: assert property ($stable(selectedAnalogInput) && !$past(reset) |->
    ((padOe ^ $past(portDir)) & ~selectedAnalogInput) == 0)
    else $error("unselected pin ignores direction");
  a_flag_or_irq: assert property (!(conversionDoneFlag_ff && convIrq_ff))
    else $error("flag and request both set");
  a_write_clears_irq: assert property (ctrlWrite |=> !convIrq_ff [*8])
    else $error("request survives control write");
  a_conv_time: assert property (s_fast_start ##1 s_quiet |-> s_quiet [*8] ##[7:14]
    (conversionDoneFlag_ff || convIrq_ff || ctrlWrite || stopMode))
    else $error("conversion length out of range");
  a_trunc_high_zero: assert property (sampleStrobe_ff && justifyModeBit0 && justifyModeBit1
    && $stable(justifyModeBit0) && $stable(justifyModeBit1) |-> resultHighReg_ff == 8'h00)
    else $error("truncation high byte nonzero");
  a_left_low_zero: assert property (sampleStrobe_ff && !justifyModeBit0
    && $stable(justifyModeBit0) |-> resultLowReg_ff[5:0] == 6'h00)
    else $error("left mode low byte unused bits set");
  a_right_high_zero: assert property (sampleStrobe_ff && justifyModeBit0 && !justifyModeBit1
    && $stable(justifyModeBit0) && $stable(justifyModeBit1) |-> resultHighReg_ff[7:2] == 6'h00)
    else $error("right mode high byte unused bits set");
  a_off_powers_down: assert property (ctrlWrite && channelSelectField == 5'h1f |->
    ##[1:3] !convPowerOn_ff)
    else $error("converter not powered off");
  a_refh_selected: assert property (ctrlWrite && channelSelectField == 5'h1d |->
    ##[1:3] highReferenceSel_ff)
    else $error("high reference not selected");
  a_stop_no_result: assert property (stopMode ##1 stopMode |->
    !$rose(convIrq_ff) && !$rose(conversionDoneFlag_ff))
    else $error("result during stop");
endmodule
bind adcc_conv_ctrl adcc_conv_ctrl_checker #(.NUM_PINS(NUM_PINS)) adcc_conv_ctrl_checker_inst (
  .clk, .reset, .ctrlWrite, .channelSelectField, .convClockDivider, .convClockSourceSel,
  .justifyModeBit0, .justifyModeBit1, .stopMode, .portDir, .padOe, .portRead,
  .selectedAnalogInput, .highReferenceSel_ff, .convPowerOn_ff, .sampleStrobe_ff,
  .resultHighReg_ff, .resultLowReg_ff, .conversionDoneFlag_ff, .convIrq_ff
);

// ===== dv/adcc_core_model.sv
// behavioural model of the analog multiplexer and converter core
`timescale 1ns/100ps
module adcc_core_model (
  // selection from the control block
  input wire [7:0] selectedAnalogInput,
  input wire highReferenceSel_ff,
  input wire lowReferenceSel_ff,
  input wire convPowerOn_ff,
  // level on the pins
  input wire [9:0] pinLevel,
  // converted code
  output reg [9:0] coreResult
);
  always @* begin
    if (!convPowerOn_ff)
      coreResult = 10'h155;
    else if (highReferenceSel_ff)
      coreResult = 10'h3ff;
    else if (lowReferenceSel_ff)
      coreResult = 10'h000;
    else if (selectedAnalogInput != 8'h00)
      coreResult = pinLevel;
    else
      coreResult = ~pinLevel;
  end
endmodule

// ===== dv/adcc_conv_ctrl_test.sv
// self-checking testbench for the converter control block
`timescale 1ns/100ps
module adcc_conv_ctrl_test;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg ctrlWrite = 1'b0, cont = 1'b0, ien = 1'b0, m0 = 1'b0, m1 = 1'b0, hiRd = 1'b0;
  reg loRd = 1'b0, stopMode = 1'b0, srcSel = 1'b1, oscTick = 1'b0;
  reg [4:0] chan = 5'h1f;
  reg [2:0] divSel = 3'h0;
  reg [7:0] portOut = 8'hff, portDir = 8'hff, padIn = 8'hff;
  reg [9:0] lvl = 10'h2b5;
  wire [9:0] core;
  wire [7:0] padOut, padOe, portRead, selIn, resHi, resLo;
  wire refH, refL, pwr, strobe, flag, irq, busy;
  integer error_cnt = 0, n_checks = 0, i, waited;
  always #50 clk = ~clk;
  adcc_conv_ctrl adcc_conv_ctrl_inst (.clk(clk), .reset(reset), .ctrlWrite(ctrlWrite),
    .channelSelectField(chan), .continuousModeBit(cont), .convIrqEnable(ien),
    .justifyModeBit0(m0), .justifyModeBit1(m1), .convClockDivider(divSel),
    .convClockSourceSel(srcSel), .oscTick(oscTick), .resultHighRead(hiRd),
    .resultLowRead(loRd), .stopMode(stopMode), .coreResult(core), .portOut(portOut),
    .portDir(portDir), .padIn(padIn), .padOut(padOut), .padOe(padOe), .portRead(portRead),
    .selectedAnalogInput(selIn), .highReferenceSel_ff(refH), .lowReferenceSel_ff(refL),
    .convPowerOn_ff(pwr), .sampleStrobe_ff(strobe), .resultHighReg_ff(resHi),
    .resultLowReg_ff(resLo), .conversionDoneFlag_ff(flag), .convIrq_ff(irq), .busy_ff(busy));
  adcc_core_model adcc_core_model_inst (.selectedAnalogInput(selIn), .highReferenceSel_ff(refH),
    .lowReferenceSel_ff(refL), .convPowerOn_ff(pwr), .pinLevel(lvl), .coreResult(core));
  // ----
  // shared tasks
  // ----
  task chk(input [15:0] seen, input [15:0] exp, input string what);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task start(input [4:0] ch, input c, input e);
    begin
      chan = ch;
      cont = c;
      ien = e;
      ctrlWrite = 1'b1;
      step(1);
      ctrlWrite = 1'b0;
    end
  endtask
  task wait_done;
    begin
      for (waited = 0; waited < 80 && (flag | irq) !== 1'b1; waited = waited + 1)
        step(1);
      chk({15'h0, flag | irq}, 16'h1, "done");
    end
  endtask
  task rd;
    begin
      hiRd = 1'b1;
      step(1);
      hiRd = 1'b0;
      loRd = 1'b1;
      step(1);
      loRd = 1'b0;
    end
  endtask
  function [15:0] fmt(input [1:0] m, input [9:0] c);
    case (m)
      2'h0: fmt = {c, 6'h00};
      2'h1: fmt = {6'h00, c};
      2'h2: fmt = {~c[9], c[8:0], 6'h00};
      default: fmt = {8'h00, c[9:2]};
    endcase
  endfunction
  // ----
  // scenarios
  // ----
  task t_pins;
    begin
      start(5'h03, 1'b0, 1'b0);
      step(2);
      chk({8'h0, selIn}, 16'h0008, "select");
      chk({8'h0, padOe}, 16'h00f7, "oe");
      chk({8'h0, portRead}, 16'h00f7, "port read");
      chk({8'h0, padOut}, 16'h00f7, "pad out");
      portDir = 8'h0f;
      step(2);
      chk({8'h0, padOe}, 16'h0007, "oe other pins");
      wait_done;
      rd;
    end
  endtask
  task t_modes;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        {m1, m0} = (i < 4) ? i[1:0] : 2'h1;
        start((i < 4) ? 5'h02 : ((i == 4) ? 5'h1d : 5'h1e), 1'b0, 1'b0);
        wait_done;
        chk({resHi, resLo}, (i < 4) ? fmt(i[1:0], lvl) : ((i == 4) ? 16'h03ff : 16'h0), "fmt");
        rd;
      end
    end
  endtask
  task t_irq;
    begin
      start(5'h02, 1'b0, 1'b1);
      wait_done;
      chk({14'h0, irq, flag}, 16'h2, "irq no flag");
      rd;
      chk({15'h0, irq}, 16'h0, "irq read clear");
      start(5'h02, 1'b0, 1'b1);
      wait_done;
      start(5'h1f, 1'b0, 1'b0);
      chk({15'h0, irq}, 16'h0, "irq write clear");
      step(1);
      chk({15'h0, pwr}, 16'h0, "power down");
    end
  endtask
  task t_lock;
    begin
      {m1, m0} = 2'h0;
      start(5'h02, 1'b1, 1'b0);
      wait_done;
      hiRd = 1'b1;
      step(1);
      hiRd = 1'b0;
      lvl = 10'h0c3;
      step(45);
      chk({resHi, resLo}, fmt(2'h0, 10'h2b5), "held");
      loRd = 1'b1;
      step(1);
      loRd = 1'b0;
      step(45);
      chk({resHi, resLo}, fmt(2'h0, 10'h0c3), "continuous");
      start(5'h1f, 1'b0, 1'b0);
      rd;
    end
  endtask
  task t_stop;
    begin
      {m1, m0} = 2'h1;
      lvl = 10'h1e7;
      start(5'h02, 1'b0, 1'b0);
      step(5);
      stopMode = 1'b1;
      step(30);
      chk({15'h0, flag}, 16'h0, "stop abort");
      stopMode = 1'b0;
      wait_done;
      chk({resHi, resLo}, 16'h01e7, "resume");
      rd;
      step(40);
      chk({15'h0, flag}, 16'h0, "single");
      chk({15'h0, busy}, 16'h0, "single idle");
    end
  endtask
  task t_restart;
    begin
      start(5'h02, 1'b0, 1'b0);
      step(14);
      // interrupted result is never read back
      start(5'h03, 1'b0, 1'b0);
      wait_done;
      chk({15'h0, waited >= 16 && waited <= 17}, 16'h1, "restart time");
      chk({8'h0, selIn}, 16'h0008, "restart channel");
      rd;
    end
  endtask
  task t_clk;
    begin
      divSel = 3'h2;
      start(5'h02, 1'b0, 1'b0);
      wait_done;
      chk({15'h0, waited >= 64 && waited <= 72}, 16'h1, "divided time");
      rd;
      divSel = 3'h0;
      srcSel = 1'b0;
      start(5'h02, 1'b0, 1'b0);
      step(30);
      chk({15'h0, flag}, 16'h0, "no source ticks");
      oscTick = 1'b1;
      wait_done;
      rd;
      srcSel = 1'b1;
      oscTick = 1'b0;
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    step(4);
    reset = 1'b0;
    chk({resHi, resLo}, 16'h0, "reset");
    t_pins;
    t_modes;
    t_irq;
    t_lock;
    t_stop;
    t_restart;
    t_clk;
    results;
  end
  initial begin
    #300000;
    error_cnt = error_cnt + 1;
    results;
  end
endmodule
